// ### core/gpc_pkg.sv
package gpc_pkg;
    // Pin counts of the port
    localparam int NPIN = 24;
    localparam int NDATA = 16;
    localparam int NADDR = 8;
    // Pins that share one sample interval
    localparam int GRP = 8;
    localparam int NGRP = 3;
    // Sample interval field width and counter width
    localparam int PRD_W = 8;
    localparam int CNT_W = 9;
    // Window lengths in samples
    localparam int WIN3_LEN = 3;
    localparam int WIN6_LEN = 6;
    // Register byte offsets
    localparam logic [7:0] A_LOW_SEL = 8'h00;
    localparam logic [7:0] A_HIGH_SEL = 8'h04;
    localparam logic [7:0] A_QSEL_LO = 8'h08;
    localparam logic [7:0] A_QSEL_HI = 8'h0c;
    localparam logic [7:0] A_QUAL_CTRL = 8'h10;
    localparam logic [7:0] A_DOUT = 8'h14;
    localparam logic [7:0] A_DIR = 8'h18;
    localparam logic [7:0] A_PIN_STAT = 8'h1c;
    localparam logic [7:0] A_ALT1_ROUTE = 8'h20;
    localparam logic [7:0] A_ALT2_ROUTE = 8'h24;
    // Levels seen by peripherals with no pin routed
    localparam logic DATA_IDLE = 1'b0;
    localparam logic ALT_ONE_IDLE = 1'b0;
    localparam logic ALT_TWO_IDLE = 1'b1;
    // Qualification settings per pin
    typedef enum logic [1:0] {
        QS_SYNC = 2'b00,
        QS_WIN3 = 2'b01,
        QS_WIN6 = 2'b10,
        QS_ASYNC = 2'b11
    } gpc_qsel_e;
    // Software visible configuration
    typedef struct packed {
        logic [31:0] low_sel;
        logic [15:0] high_sel;
        logic [31:0] qsel_lo;
        logic [15:0] qsel_hi;
        logic [23:0] prd;
        logic [23:0] dout;
        logic [23:0] dir;
        logic [23:0] alt1;
        logic [23:0] alt2;
    } gpc_cfg_s;
    // Everything clears at reset
    localparam gpc_cfg_s CFG_RST = '0;
endpackage

// ### core/gpc_sync2.sv
`timescale 1ns/1ps
module gpc_sync2 #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Asynchronous in, synchronous out
    input wire logic [W-1:0] d,
    output logic [W-1:0] sync_q
);
    // First stage, read only by the second
    logic [W-1:0] meta_q;

    // Two flop chain against metastability
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end
endmodule

// ### core/gpc_qual.sv
`timescale 1ns/1ps
module gpc_qual (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pin level, synchronised and raw
    input wire logic sync_in,
    input wire logic raw_in,
    // Sample strobe of this pin's group
    input wire logic tick,
    // Qualification setting
    input wire logic [1:0] qsel,
    // Conditioned level
    output logic qual_out
);
    gpc_pkg::gpc_qsel_e mode;
    // Sample history, newest in bit 0
    logic [gpc_pkg::WIN6_LEN-1:0] hist_q;
    logic [gpc_pkg::WIN6_LEN-1:0] hist_d;
    logic qual_q;
    logic qual_d;
    logic all1;
    logic all0;

    assign mode = gpc_pkg::gpc_qsel_e'(qsel);

    // Window check on the history as it will be after this sample
    always_comb begin
        hist_d = tick ? {hist_q[gpc_pkg::WIN6_LEN-2:0], sync_in} : hist_q;
        if (mode == gpc_pkg::QS_WIN6) begin
            all1 = &hist_d;
            all0 = ~|hist_d;
        end else begin
            all1 = &hist_d[gpc_pkg::WIN3_LEN-1:0];
            all0 = ~|hist_d[gpc_pkg::WIN3_LEN-1:0];
        end
        qual_d = qual_q;
        case (mode)
            gpc_pkg::QS_WIN3, gpc_pkg::QS_WIN6: begin
                // Change only on a sample, and only on full agreement
                if (tick && all1) begin
                    qual_d = 1'b1;
                end else if (tick && all0) begin
                    qual_d = 1'b0;
                end
            end
            // Otherwise track, so a later switch starts from a sane level
            default: qual_d = sync_in;
        endcase
    end

    // History and held output
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            hist_q <= '0;
            qual_q <= 1'b0;
        end else begin
            hist_q <= hist_d;
            qual_q <= qual_d;
        end
    end

    // Async setting bypasses every flop; the peripheral must cope
    assign qual_out = (mode == gpc_pkg::QS_ASYNC) ? raw_in :
                      (mode == gpc_pkg::QS_SYNC) ? sync_in : qual_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    win3_agree_a: assert property (
        ($past(qsel) == 2'b01 && qual_q != $past(qual_q))
        |-> hist_q[2:0] == {3{qual_q}})
        else $error("3-sample window changed without agreement");
    win6_agree_a: assert property (
        ($past(qsel) == 2'b10 && qual_q != $past(qual_q))
        |-> hist_q == {6{qual_q}})
        else $error("6-sample window changed without agreement");
    hold_no_tick_a: assert property (
        ($past(qsel) inside {2'b01, 2'b10} && !$past(tick)) |-> $stable(qual_q))
        else $error("qualified level moved between samples");
    async_pass_a: assert property (
        (qsel == 2'b11) |-> qual_out == raw_in)
        else $error("async setting not passing raw pin");
    sync_only_a: assert property (
        (qsel == 2'b00) [*2] |-> qual_out == sync_in && qual_q == $past(sync_in))
        else $error("sync setting not following synchroniser");
endmodule

// ### core/gpc_portc_mux.sv
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module gpc_portc_mux (
    // Clock and reset
    input wire logic MCLK,
    input wire logic NRST,
    // APB slave
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    // Board pins, split into in, out and enable
    input wire logic [23:0] PIN_IN,
    output logic [23:0] PIN_OUT,
    output logic [23:0] PIN_OE_N,
    // External memory interface side
    input wire logic [15:0] EXT_DATA_OUT,
    input wire logic [15:0] EXT_DATA_DRIVE,
    input wire logic [7:0] EXT_ADDR_HI,
    output logic [15:0] EXT_DATA_IN,
    // Conditioned pin levels to peripherals
    output logic [23:0] QUAL_IN,
    output logic ALT_FUNC_ONE_IN,
    output logic ALT_FUNC_TWO_IN
);
    // Configuration registers
    gpc_pkg::gpc_cfg_s cfg_q;
    // Bus answer registers
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    // Read mux result for the setup cycle
    logic [31:0] rd_d;
    logic err_d;
    // Setup and committed write phases
    logic setup;
    logic wr_en;
    // Pin path: synchronised, conditioned, then the
    // memory bus select, value and enable per pin
    logic [23:0] pin_sync;
    logic [23:0] pin_qual;
    logic [23:0] ext_sel;
    logic [23:0] ext_out;
    logic [23:0] ext_oe_n;
    logic [23:0] out_q;
    logic [23:0] oe_n_q;
    // One sample strobe per group of eight pins
    // Pins 8g to 8g+7 share one interval field
    logic [gpc_pkg::NGRP-1:0] tick;
    // Routing terms for the two multi-pin inputs
    logic alt1_or;
    logic alt2_and;

    // Bus phases
    // The slave never stretches a transfer, so a
    // write commits on the single ready edge
    assign setup = PSEL && !PENABLE;
    assign wr_en = PSEL && PENABLE && pready_q && PWRITE;

    // Read decode; unmapped addresses flag an error
    // Decoded from the live address in the setup
    // cycle, so the answer is ready one edge later
    always_comb begin
        rd_d = 32'h0000_0000;
        err_d = 1'b0;
        if (PADDR == gpc_pkg::A_LOW_SEL) begin
            rd_d = cfg_q.low_sel;
        end else if (PADDR == gpc_pkg::A_HIGH_SEL) begin
            // Upper half is reserved and reads zero
            rd_d = {16'h0000, cfg_q.high_sel};
        end else if (PADDR == gpc_pkg::A_QSEL_LO) begin
            rd_d = cfg_q.qsel_lo;
        end else if (PADDR == gpc_pkg::A_QSEL_HI) begin
            rd_d = {16'h0000, cfg_q.qsel_hi};
        end else if (PADDR == gpc_pkg::A_QUAL_CTRL) begin
            rd_d = {8'h00, cfg_q.prd};
        end else if (PADDR == gpc_pkg::A_DOUT) begin
            rd_d = {8'h00, cfg_q.dout};
        end else if (PADDR == gpc_pkg::A_DIR) begin
            rd_d = {8'h00, cfg_q.dir};
        end else if (PADDR == gpc_pkg::A_PIN_STAT) begin
            // Live conditioned levels, whatever the pin carries
            rd_d = {8'h00, pin_qual};
        end else if (PADDR == gpc_pkg::A_ALT1_ROUTE) begin
            rd_d = {8'h00, cfg_q.alt1};
        end else if (PADDR == gpc_pkg::A_ALT2_ROUTE) begin
            rd_d = {8'h00, cfg_q.alt2};
        end else begin
            err_d = 1'b1;
        end
    end

    // Answer registers: one wait-free access phase per transfer
    // Ready is a one-cycle pulse; the master must take
    // the answer on that edge and not wait for another
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= setup;
            if (setup) begin
                pslverr_q <= err_d;
                // Writes read back zero rather than stale data
                prdata_q <= PWRITE ? 32'h0000_0000 : rd_d;
            end
        end
    end

    // Register writes; the status word is read-only and ignores them
    // Only the upper bit of each mux field is used;
    // both lower codes leave the pin a general I/O
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            cfg_q <= gpc_pkg::CFG_RST;
        end else if (wr_en) begin
            // Writes land only on the ready edge
            if (PADDR == gpc_pkg::A_LOW_SEL) begin
                cfg_q.low_sel <= PWDATA;
            end else if (PADDR == gpc_pkg::A_HIGH_SEL) begin
                cfg_q.high_sel <= PWDATA[15:0];
            end else if (PADDR == gpc_pkg::A_QSEL_LO) begin
                cfg_q.qsel_lo <= PWDATA;
            end else if (PADDR == gpc_pkg::A_QSEL_HI) begin
                cfg_q.qsel_hi <= PWDATA[15:0];
            end else if (PADDR == gpc_pkg::A_QUAL_CTRL) begin
                cfg_q.prd <= PWDATA[23:0];
            end else if (PADDR == gpc_pkg::A_DOUT) begin
                cfg_q.dout <= PWDATA[23:0];
            end else if (PADDR == gpc_pkg::A_DIR) begin
                cfg_q.dir <= PWDATA[23:0];
            end else if (PADDR == gpc_pkg::A_ALT1_ROUTE) begin
                cfg_q.alt1 <= PWDATA[23:0];
            end else if (PADDR == gpc_pkg::A_ALT2_ROUTE) begin
                cfg_q.alt2 <= PWDATA[23:0];
            end
        end
    end

    // Bus answers come straight from their flops
    assign PRDATA = prdata_q;
    assign PREADY = pready_q;
    assign PSLVERR = pslverr_q;

    // Every pin passes two flops before any logic reads it
    // The async setting still taps the raw pin, since
    // its peripheral does its own synchronisation
    gpc_sync2 #(
        .W(gpc_pkg::NPIN)
    ) u_sync (
        .clk(MCLK),
        .rst_n(NRST),
        .d(PIN_IN),
        .sync_q(pin_sync)
    );

    // Sample interval per group: 0 samples every clock, n every 2n
    // The counter runs free and a write never clears
    // it, so the first interval after a change can
    // be shorter than the new setting
    for (genvar g = 0; g < gpc_pkg::NGRP; g++) begin : g_grp
        logic [gpc_pkg::PRD_W-1:0] prd;
        logic [gpc_pkg::CNT_W-1:0] limit;
        logic [gpc_pkg::CNT_W-1:0] cnt_q;
        assign prd = cfg_q.prd[g*gpc_pkg::PRD_W +: gpc_pkg::PRD_W];
        // Interval F becomes a count limit of 2F-1
        assign limit = (prd == 8'h00) ? 9'h000 : {prd, 1'b0} - 9'h001;
        // Compare with >= so a shortened interval never stalls
        assign tick[g] = (cnt_q >= limit);
        // Free running interval counter
        always_ff @(posedge MCLK or negedge NRST) begin
            if (!NRST) begin
                cnt_q <= 9'h000;
            end else if (tick[g]) begin
                cnt_q <= 9'h000;
            end else begin
                cnt_q <= cnt_q + 9'h001;
            end
        end
    end

    // Per pin: function select, qualification, memory bus routing
    // Pins 0-15 carry data both ways, pins 16-23
    // only drive address; every pin is conditioned
    for (genvar i = 0; i < gpc_pkg::NPIN; i++) begin : g_pin
        logic [1:0] qsel;
        if (i < gpc_pkg::NDATA) begin : g_data
            // Data pins run in reverse: pin 0 carries the top bit
            assign qsel = cfg_q.qsel_lo[2*i +: 2];
            assign ext_sel[i] = cfg_q.low_sel[2*i+1];
            assign ext_out[i] = EXT_DATA_OUT[gpc_pkg::NDATA-1-i];
            assign ext_oe_n[i] = !EXT_DATA_DRIVE[gpc_pkg::NDATA-1-i];
            // Returned data bit, idle when the pin is a general I/O
            assign EXT_DATA_IN[gpc_pkg::NDATA-1-i] =
                ext_sel[i] ? pin_qual[i] : gpc_pkg::DATA_IDLE;
        end else begin : g_addr
            // Address pins always drive while selected
            assign qsel = cfg_q.qsel_hi[2*(i-gpc_pkg::NDATA) +: 2];
            assign ext_sel[i] = cfg_q.high_sel[2*(i-gpc_pkg::NDATA)+1];
            assign ext_out[i] = EXT_ADDR_HI[i-gpc_pkg::NDATA];
            assign ext_oe_n[i] = 1'b0;
        end
        // Input conditioner
        gpc_qual u_qual (
            .clk(MCLK),
            .rst_n(NRST),
            .sync_in(pin_sync[i]),
            .raw_in(PIN_IN[i]),
            .tick(tick[i/gpc_pkg::GRP]),
            .qsel(qsel),
            .qual_out(pin_qual[i])
        );
    end

    // Pin drivers; one flop stage keeps pads glitch free
    // Trade-off: memory bus values reach the pads one
    // cycle late, so its timing must allow for it
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            out_q <= 24'h000000;
            // All pins float until software asks otherwise
            oe_n_q <= 24'hffffff;
        end else begin
            out_q <= (ext_sel & ext_out) | (~ext_sel & cfg_q.dout);
            oe_n_q <= (ext_sel & ext_oe_n) | (~ext_sel & ~cfg_q.dir);
        end
    end

    // Pad controls leave from flops; conditioned levels do not
    assign PIN_OUT = out_q;
    assign PIN_OE_N = oe_n_q;
    assign QUAL_IN = pin_qual;

    // Several pins may feed one input; idle-low inputs OR, idle-high AND
    // An unrouted pin then can never pull the input
    // away from its idle level
    assign alt1_or = |(pin_qual & cfg_q.alt1);
    assign alt2_and = &(pin_qual | ~cfg_q.alt2);
    // With no pin routed the input rests at its idle level
    assign ALT_FUNC_ONE_IN = (cfg_q.alt1 == 24'h000000) ?
                             gpc_pkg::ALT_ONE_IDLE : alt1_or;
    assign ALT_FUNC_TWO_IN = (cfg_q.alt2 == 24'h000000) ?
                             gpc_pkg::ALT_TWO_IDLE : alt2_and;

    // All checks below run on the system clock and
    // are switched off while reset is held
    default clocking @(posedge MCLK); endclocking
    default disable iff (!NRST);

    // Committed APB write to the qualification control word
    sequence s_wr_ctrl;
        PSEL && PENABLE && PREADY && PWRITE && PADDR == gpc_pkg::A_QUAL_CTRL;
    endsequence

    // Setup then access of a status read
    sequence s_rd_stat;
        PSEL && !PENABLE && !PWRITE && PADDR == gpc_pkg::A_PIN_STAT ##1 PSEL && PENABLE;
    endsequence

    // Pin 0 on the bus drives the top data bit
    data_pin_mux_a: assert property (
        cfg_q.low_sel[1] |=> PIN_OUT[0] == $past(EXT_DATA_OUT[15])
            && PIN_OE_N[0] == !$past(EXT_DATA_DRIVE[15]))
        else $error("pin 0 not carrying top data bit");

    // Pin 15 left as general I/O follows its registers
    gpio_pin_a: assert property (
        !cfg_q.low_sel[31] |=> PIN_OUT[15] == $past(cfg_q.dout[15])
            && PIN_OE_N[15] == !$past(cfg_q.dir[15]))
        else $error("pin 15 not acting as general I/O");

    // Pin 23 on the bus drives the top address bit
    addr_pin_mux_a: assert property (
        cfg_q.high_sel[15] |=> PIN_OUT[23] == $past(EXT_ADDR_HI[7]) && !PIN_OE_N[23])
        else $error("pin 23 not driving top address bit");

    // Pin 23 released again behaves as general I/O
    addr_gpio_a: assert property (
        !cfg_q.high_sel[15] |=> PIN_OE_N[23] == !$past(cfg_q.dir[23]))
        else $error("pin 23 not released as general I/O");

    // The level of pin 0 comes back on data bit 15
    data_return_a: assert property (
        cfg_q.low_sel[1] |-> EXT_DATA_IN[15] == pin_qual[0])
        else $error("pin 0 level not returned on top data bit");

    // Reset leaves every pin synchronise-only
    qsel_reset_a: assert property (
        $rose(NRST) |-> cfg_q.qsel_lo == 32'h0 && cfg_q.qsel_hi == 16'h0)
        else $error("qualification not sync-only after reset");

    // The interval field takes the written word
    ctrl_write_a: assert property (
        s_wr_ctrl |=> cfg_q.prd == $past(PWDATA[23:0]))
        else $error("interval field not written");

    // Interval 2 gives exactly three idle clocks
    tick_period_a: assert property (
        (tick[0] && cfg_q.prd[7:0] == 8'h02) ##1 (cfg_q.prd[7:0] == 8'h02) [*4] |->
            tick[0] && !$past(tick[0]) && !$past(tick[0], 2) && !$past(tick[0], 3))
        else $error("interval 2 does not sample every 4 clocks");

    // Interval 0 samples on every clock
    tick_fast_a: assert property (
        cfg_q.prd[15:8] == 8'h00 |-> tick[1])
        else $error("interval 0 not sampling every clock");

    // Status reads answer at once with no error
    stat_read_a: assert property (
        s_rd_stat |-> PREADY && PRDATA[31:24] == 8'h00 && !PSLVERR)
        else $error("status read answer wrong");

    // Any routed high pin raises the idle-low input
    alt_multi_a: assert property (
        (cfg_q.alt1[2] && cfg_q.alt1[3] && (pin_qual[2] || pin_qual[3]))
            |-> ALT_FUNC_ONE_IN)
        else $error("second routed pin ignored");

    // Any routed low pin pulls the idle-high input down
    alt_two_and_a: assert property (
        (cfg_q.alt2[3:2] == 2'b11 && pin_qual[3:2] != 2'b11)
            |-> !ALT_FUNC_TWO_IN)
        else $error("routed low pin did not pull input down");

    // With nothing routed the inputs sit idle
    alt_idle_a: assert property (
        (cfg_q.alt2 == 24'h0 && !cfg_q.low_sel[1]) |->
            ALT_FUNC_TWO_IN && !EXT_DATA_IN[15])
        else $error("unrouted input not at idle level");
endmodule

// ### test/gpc_pad_model.sv
`timescale 1ns/1ps
// Board side of the pads: a pin the core drives reads back its own value,
// any other pin shows the level the board puts on it
module gpc_pad_model (
    // Core side of the pads
    input wire logic [23:0] pin_out,
    input wire logic [23:0] pin_oe_n,
    // Level the board applies where the core lets go
    input wire logic [23:0] board_lvl,
    // Level seen by the pad input buffers
    output logic [23:0] pin_in
);
    // Wire resolution per bit; a low enable means the core owns the wire
    always_comb begin
        for (int i = 0; i < 24; i++) begin
            pin_in[i] = pin_oe_n[i] ? board_lvl[i] : pin_out[i];
        end
    end
endmodule

// ### test/gpc_portc_mux_tb_top.sv
`timescale 1ns/1ps
module gpc_portc_mux_tb_top;
    // Clock, reset and APB master
    logic MCLK = 1'b0;
    logic NRST = 1'b0;
    logic PSEL = 1'b0;
    logic PENABLE = 1'b0;
    logic PWRITE = 1'b0;
    logic [7:0] PADDR = 8'h00;
    logic [31:0] PWDATA = 32'h0;
    logic [31:0] PRDATA;
    logic PREADY;
    logic PSLVERR;
    // Pads and memory bus side
    logic [23:0] PIN_IN;
    logic [23:0] PIN_OUT;
    logic [23:0] PIN_OE_N;
    logic [23:0] board_lvl = 24'h0;
    logic [15:0] EXT_DATA_OUT = 16'h0;
    logic [15:0] EXT_DATA_DRIVE = 16'h0;
    logic [7:0] EXT_ADDR_HI = 8'h00;
    logic [15:0] EXT_DATA_IN;
    logic [23:0] QUAL_IN;
    logic ALT_FUNC_ONE_IN;
    logic ALT_FUNC_TWO_IN;
    // Scoreboard counters
    int mismatches = 0;
    int cmp_count = 0;
    // Readable bits per register slot; the status slot is read only
    logic [31:0] rmask [10] = '{32'hffffffff, 32'h0000ffff, 32'hffffffff, 32'h0000ffff,
        32'h00ffffff, 32'h00ffffff, 32'h00ffffff, 32'h0, 32'h00ffffff, 32'h00ffffff};
    // Filtered pins: pin, earliest and latest cycle of the rise
    int fpin [4] = '{0, 1, 8, 16};
    int lo [4] = '{10, 22, 4, 12};
    int hi [4] = '{17, 29, 8, 17};
    int rise [4] = '{0, 0, 0, 0};
    logic held;

    gpc_portc_mux DUT (.MCLK(MCLK), .NRST(NRST), .PSEL(PSEL), .PENABLE(PENABLE),
        .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
        .PSLVERR(PSLVERR), .PIN_IN(PIN_IN), .PIN_OUT(PIN_OUT), .PIN_OE_N(PIN_OE_N),
        .EXT_DATA_OUT(EXT_DATA_OUT), .EXT_DATA_DRIVE(EXT_DATA_DRIVE),
        .EXT_ADDR_HI(EXT_ADDR_HI), .EXT_DATA_IN(EXT_DATA_IN), .QUAL_IN(QUAL_IN),
        .ALT_FUNC_ONE_IN(ALT_FUNC_ONE_IN), .ALT_FUNC_TWO_IN(ALT_FUNC_TWO_IN));

    gpc_pad_model board (.pin_out(PIN_OUT), .pin_oe_n(PIN_OE_N), .board_lvl(board_lvl),
        .pin_in(PIN_IN));

    // 125 MHz system clock
    always #4 MCLK = ~MCLK;

    // Verdict and end of run
    task automatic stop_test();
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // Compare with four-state equality so unknowns never match
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Wait for rising edges; callers drive right after and sample after #1
    task automatic tick(input int n);
        repeat (n) @(posedge MCLK);
    endtask

    // One APB transfer; the request holds until PREADY is seen high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd, output logic err);
        int n;
        @(posedge MCLK);
        PSEL <= 1'b1;
        PWRITE <= w;
        PADDR <= a;
        PWDATA <= wd;
        @(posedge MCLK);
        PENABLE <= 1'b1;
        n = 0;
        do begin
            @(posedge MCLK);
            n++;
        end while (PREADY !== 1'b1 && n < 16);
        // A slave that never answers ends the run
        if (PREADY !== 1'b1) begin
            mismatches++;
            stop_test();
        end else begin
            rd = PRDATA;
            err = PSLVERR;
            PSEL <= 1'b0;
            PENABLE <= 1'b0;
        end
    endtask

    // Register write, response ignored
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask

    // Register read against expected data and error flag
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check(e, exp_err);
    endtask

    // Pin i carries data bit 15-i
    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        for (int i = 0; i < 16; i++) begin
            r[i] = v[15 - i];
        end
        return r;
    endfunction

    // Hang guard
    initial begin
        tick(20000);
        mismatches++;
        stop_test();
    end

    // Main sequence
    initial begin
        logic [31:0] r;
        logic e;
        tick(5);
        NRST <= 1'b1;
        #1;
        check(PIN_OE_N, 24'hffffff);
        check(ALT_FUNC_ONE_IN, gpc_pkg::ALT_ONE_IDLE);
        check(ALT_FUNC_TWO_IN, gpc_pkg::ALT_TWO_IDLE);
        // Reset values, then all ones to find the implemented bits
        for (int i = 0; i < 10; i++) rd_chk(8'(4 * i), 32'h0, 1'b0);
        for (int i = 0; i < 10; i++) if (i != 7) wr(8'(4 * i), 32'hffffffff);
        for (int i = 0; i < 10; i++) if (i != 7) rd_chk(8'(4 * i), rmask[i], 1'b0);
        for (int i = 0; i < 10; i++) wr(8'(4 * i), 32'h0);
        // Unmapped slot answers with an error
        apb(1'b1, 8'h28, 32'hffffffff, r, e);
        check(e, 1'b1);
        rd_chk(8'h28, 32'h0, 1'b1);
        // Default setting: two edges of synchroniser latency
        board_lvl[4] <= 1'b1;
        tick(1);
        #1;
        check(QUAL_IN[4], 1'b0);
        tick(1);
        #1;
        check(QUAL_IN[4], 1'b1);
        // Memory data bus on pins 0-15 for codes 10 and 11; code 01 stays general I/O
        tick(1);
        EXT_DATA_OUT <= 16'hc35a;
        EXT_DATA_DRIVE <= 16'hffff;
        for (int c = 1; c < 4; c++) begin
            wr(gpc_pkg::A_LOW_SEL, {16{2'(c)}});
            tick(3);
            #1;
            check(PIN_OE_N[15:0], (c > 1) ? 16'h0 : 16'hffff);
            if (c > 1) check(PIN_OUT[15:0], rev16(16'hc35a));
        end
        // Bus released: pad levels come back on the data inputs
        tick(1);
        EXT_DATA_DRIVE <= 16'h0;
        board_lvl[15:0] <= 16'h1234;
        tick(4);
        #1;
        check(PIN_OE_N[15:0], 16'hffff);
        check(EXT_DATA_IN, rev16(16'h1234));
        wr(gpc_pkg::A_LOW_SEL, {16{2'b01}});
        #1;
        check(EXT_DATA_IN, {16{gpc_pkg::DATA_IDLE}});
        // Address lines on pins 16-23
        tick(1);
        EXT_ADDR_HI <= 8'h5a;
        board_lvl <= 24'h0;
        wr(gpc_pkg::A_HIGH_SEL, 32'h0000aaaa);
        tick(3);
        #1;
        check(PIN_OUT[23:16], 8'h5a);
        check(PIN_OE_N[23:16], 8'h00);
        wr(gpc_pkg::A_HIGH_SEL, 32'h00005555);
        tick(3);
        #1;
        check(PIN_OE_N[23:16], 8'hff);
        // Filters: pins 0,1 interval 2; pin 8 every clock; pin 16 interval 1
        wr(gpc_pkg::A_QSEL_LO, 32'h000100f9);
        wr(gpc_pkg::A_QSEL_HI, 32'h00000002);
        wr(gpc_pkg::A_QUAL_CTRL, 32'h00010002);
        tick(40);
        board_lvl <= 24'h010103;
        for (int n = 1; n <= 40; n++) begin
            tick(1);
            #1;
            for (int k = 0; k < 4; k++) if (rise[k] == 0 && QUAL_IN[fpin[k]] === 1'b1) rise[k] = n;
        end
        for (int k = 0; k < 4; k++) check(rise[k] >= lo[k] && rise[k] <= hi[k], 1'b1);
        // A dip shorter than the window must not pass
        tick(1);
        board_lvl[0] <= 1'b0;
        board_lvl[8] <= 1'b0;
        tick(2);
        board_lvl[0] <= 1'b1;
        board_lvl[8] <= 1'b1;
        held = 1'b1;
        for (int n = 0; n < 30; n++) begin
            tick(1);
            #1;
            if (QUAL_IN[0] !== 1'b1 || QUAL_IN[8] !== 1'b1) held = 1'b0;
        end
        check(held, 1'b1);
        // Setting 11 shows the pad with no clock edge in between
        tick(1);
        board_lvl[2] <= 1'b1;
        #1;
        check(QUAL_IN[2], 1'b1);
        // Two pins routed to each peripheral input, all four combinations
        wr(gpc_pkg::A_ALT1_ROUTE, 32'h0000000c);
        wr(gpc_pkg::A_ALT2_ROUTE, 32'h0000000c);
        for (int k = 0; k < 4; k++) begin
            tick(1);
            board_lvl[3:2] <= 2'(k);
            #1;
            check(ALT_FUNC_ONE_IN, k != 0);
            check(ALT_FUNC_TWO_IN, k == 3);
        end
        // Unrouted inputs return to their idle levels
        wr(gpc_pkg::A_ALT1_ROUTE, 32'h0);
        wr(gpc_pkg::A_ALT2_ROUTE, 32'h0);
        #1;
        check(ALT_FUNC_ONE_IN, gpc_pkg::ALT_ONE_IDLE);
        tick(1);
        board_lvl[3:2] <= 2'b00;
        #1;
        check(ALT_FUNC_TWO_IN, gpc_pkg::ALT_TWO_IDLE);
        stop_test();
    end
endmodule
